// File: rtl/pcr_defs.svh
// constants for the peripheral control register bank
// assumes a 12-bit cpu data-memory address and 4-bit data path
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PCR_BUZZER_ENVELOPE_CTRL 12'hF75
`define PCR_TIMER_CLEAR_STROBES  12'hF76
`define PCR_STOPWATCH_CTRL       12'hF77
`define PCR_PROG_TIMER_CTRL      12'hF78
`define PCR_PROG_TIMER_CLOCK_CFG 12'hF79
`define PCR_SERIAL_CLOCK_CFG     12'hF7A
`define PCR_OUTPUT_FLOAT_CTRL    12'hF7B
`define PCR_IO_DIRECTION_CTRL    12'hF7D
`define PCR_IO_PULLUP_CTRL       12'hF7E

// ----------------------------------------
// field positions
// ----------------------------------------
`define PCR_BIT_D3 3
`define PCR_BIT_D2 2
`define PCR_BIT_D1 1
`define PCR_BIT_D0 0

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define PCR_RESET_NIBBLE 4'h0
`define PCR_RESET_BIT    1'h0
// one-shot buzzer pulse widths in microseconds
`define PCR_SHOT_LONG_US  62500
`define PCR_SHOT_SHORT_US 31250
`define PCR_CLOCK_MHZ     250

`endif

// File: rtl/pcr_pkg.sv
// types for the peripheral control register bank
// assumes pcr_defs.svh supplies all numeric constants
package pcr_pkg;

  // cpu access to the data memory
  typedef struct packed {
    logic [11:0] addr;
    logic [3:0]  wdata;
    logic        wr;
    logic        rd;
  } pcr_bus_type;

  // control outputs to the peripherals
  typedef struct packed {
    logic       envelope_enable;
    logic       envelope_period_sel;
    logic       lap_timer_go;
    logic       prog_timer_go;
    logic       prog_timer_clk_out;
    logic [2:0] prog_timer_src_sel;
    logic       serial_clk_edge_sel;
    logic [1:0] serial_clk_src_sel;
    logic [3:0] out_port_float;
    logic [3:0] io_port_dir;
    logic [3:0] io_port_pullup_sel;
  } pcr_ctrl_type;

  // one-cycle strobes to the peripherals
  typedef struct packed {
    logic envelope_restart;
    logic tick_timer_clear;
    logic dog_timer_clear;
    logic lap_timer_clear;
    logic prog_timer_clear;
    logic serial_clk_fire;
    logic oneshot_buzzer_fire;
  } pcr_strobe_type;

  // one-shot buzzer states
  typedef enum logic [0:0] {
    PCR_SHOT_READY = 1'b0,
    PCR_SHOT_BUSY  = 1'b1
  } pcr_shot_type;

endpackage : pcr_pkg

// File: rtl/pcr_regs.sv
// peripheral control register bank of a 4-bit microcontroller
// assumes cpu strobes are synchronous to clock; shot width select comes from another register
// assumes each cpu access holds wr or rd high for one clock with the address steady
// assumes shot_width_long is a level on this clock, so it needs no synchroniser
//
// Overview of operation
// [R1] writing one to buzzer_envelope_ctrl bit 3 fires a single buzzer pulse, and that bit reads one while busy.
// [R2] write-only strobe and trigger bits read zero, except buzzer_envelope_ctrl bit 3, which reads the busy state.
// [R3] bits 3 and 2 of timer_clear_strobes, stopwatch_ctrl and prog_timer_ctrl hold nothing and read zero.
// [R4] initial reset clears every stored control bit.
// [R5] prog_timer_clock_cfg bit 3 turns the programmable timer clock output on.
// [R6] prog_timer_clock_cfg bits 2..0 select the programmable timer input clock.
// [R7] writing one to serial_clock_cfg bit 3 triggers the serial clock, write-only.
// [R8] serial_clock_cfg bit 2 selects the serial clock edge, read/write.
// [R9] serial_clock_cfg bits 1..0 select the serial clock mode, read/write.
// [R10] each output_float_ctrl bit drives one output group when one and floats it when zero.
// [R11] each io_pullup_ctrl bit turns one i/o group pull-up off when one and on when zero.
// [R12] each io_direction_ctrl bit sets one i/o group to output when one and input when zero.
// [R13] run bits start counting when one, and envelope bits pick on/off and 1.0 s or 0.5 s.
`timescale 1ns/10ps
`include "pcr_defs.svh"
`default_nettype none

module pcr_regs (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire pcr_pkg::pcr_bus_type bus,
  input  wire logic                shot_width_long,
  output logic [3:0]               rdata,
  output pcr_pkg::pcr_ctrl_type    ctrl,
  output pcr_pkg::pcr_strobe_type  strobe,
  output logic                     buzzer_shot_active
);

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned LONG_CYCLES  = `PCR_SHOT_LONG_US * `PCR_CLOCK_MHZ;
  localparam int unsigned SHORT_CYCLES = `PCR_SHOT_SHORT_US * `PCR_CLOCK_MHZ;
  // both lengths fit well inside 32 bits at this clock rate

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // full 12-bit compare, so no alias reaches the neighbouring registers
  // unmapped offsets, the gap at f7ch too, ignore writes and read zero
  wire logic wr_f75 = bus.wr && (bus.addr == `PCR_BUZZER_ENVELOPE_CTRL);
  wire logic wr_f76 = bus.wr && (bus.addr == `PCR_TIMER_CLEAR_STROBES);
  wire logic wr_f77 = bus.wr && (bus.addr == `PCR_STOPWATCH_CTRL);
  wire logic wr_f78 = bus.wr && (bus.addr == `PCR_PROG_TIMER_CTRL);
  wire logic wr_f79 = bus.wr && (bus.addr == `PCR_PROG_TIMER_CLOCK_CFG);
  wire logic wr_f7a = bus.wr && (bus.addr == `PCR_SERIAL_CLOCK_CFG);
  wire logic wr_f7b = bus.wr && (bus.addr == `PCR_OUTPUT_FLOAT_CTRL);
  wire logic wr_f7d = bus.wr && (bus.addr == `PCR_IO_DIRECTION_CTRL);
  wire logic wr_f7e = bus.wr && (bus.addr == `PCR_IO_PULLUP_CTRL);
  wire logic [3:0] wd = bus.wdata;

  // ----------------------------------------
  // stored control bits
  // ----------------------------------------
  // serial config keeps edge and mode only, its trigger is a strobe
  // shot_count is wide enough for the long pulse at this clock
  logic                 envelope_enable;
  logic                 envelope_period_sel;
  logic                 lap_timer_go;
  logic                 prog_timer_go;
  logic [3:0]           prog_timer_clock_cfg;
  logic [2:0]           serial_clock_cfg;
  logic [3:0]           output_float_ctrl;
  logic [3:0]           io_direction_ctrl;
  logic [3:0]           io_pullup_ctrl;
  pcr_pkg::pcr_shot_type shot_state;
  pcr_pkg::pcr_shot_type next_shot_state;
  logic [31:0]          shot_count;
  logic [31:0]          next_shot_count;

  // control register writes
  // write-only bits are not stored here, the strobe block pulses them
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      envelope_enable      <= `PCR_RESET_BIT;    // see [R4]
      envelope_period_sel  <= `PCR_RESET_BIT;
      lap_timer_go         <= `PCR_RESET_BIT;
      prog_timer_go        <= `PCR_RESET_BIT;
      prog_timer_clock_cfg <= `PCR_RESET_NIBBLE;
      serial_clock_cfg     <= 3'h0;
      output_float_ctrl    <= `PCR_RESET_NIBBLE;
      io_direction_ctrl    <= `PCR_RESET_NIBBLE;
      io_pullup_ctrl       <= `PCR_RESET_NIBBLE;
    end else begin
      if (wr_f75) begin
        envelope_period_sel <= wd[`PCR_BIT_D1];  // see [R13]
        envelope_enable     <= wd[`PCR_BIT_D0];  // see [R13]
      end
      if (wr_f77) lap_timer_go <= wd[`PCR_BIT_D0];   // see [R13]
      if (wr_f78) prog_timer_go <= wd[`PCR_BIT_D0];  // see [R13]
      if (wr_f79) prog_timer_clock_cfg <= wd;        // see [R5] see [R6]
      if (wr_f7a) serial_clock_cfg <= wd[2:0];       // see [R8] see [R9]
      if (wr_f7b) output_float_ctrl <= wd;           // see [R10]
      if (wr_f7d) io_direction_ctrl <= wd;           // see [R12]
      if (wr_f7e) io_pullup_ctrl <= wd;              // see [R11]
    end
  end

  // ----------------------------------------
  // one-shot buzzer
  // ----------------------------------------
  // a one at bit 3 of the buzzer register asks for a shot
  wire logic shot_fire = wr_f75 && wd[`PCR_BIT_D3];
  wire logic [31:0] shot_len = shot_width_long ? LONG_CYCLES : SHORT_CYCLES;

  // next-state for the pulse timer, retrigger while busy ignored
  // dropping a retrigger keeps one write from stretching a running pulse
  // loading length minus one keeps busy high for exactly shot_len cycles
  always_comb begin
    next_shot_state = shot_state;
    next_shot_count = shot_count;
    case (shot_state)
      pcr_pkg::PCR_SHOT_READY: begin
        if (shot_fire) begin                     // see [R1]
          next_shot_state = pcr_pkg::PCR_SHOT_BUSY;
          next_shot_count = shot_len - 32'h1;
        end
      end
      pcr_pkg::PCR_SHOT_BUSY: begin
        if (shot_count == 32'h0) begin
          next_shot_state = pcr_pkg::PCR_SHOT_READY;
        end else begin
          next_shot_count = shot_count - 32'h1;
        end
      end
      default: next_shot_state = pcr_pkg::PCR_SHOT_READY;
    endcase
  end

  // pulse timer state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shot_state <= pcr_pkg::PCR_SHOT_READY;
      shot_count <= 32'h0;
    end else begin
      shot_state <= next_shot_state;
      shot_count <= next_shot_count;
    end
  end

  // busy comes straight from the state flop, so it never glitches
  assign buzzer_shot_active = (shot_state == pcr_pkg::PCR_SHOT_BUSY); // see [R1]

  // ----------------------------------------
  // strobes, one cycle per write of one
  // ----------------------------------------
  // registered so each pulse lines up with the levels of the same write
  // a fire request while busy gives no fire pulse either
  // the envelope restart is a plain pulse with no busy state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strobe <= '0;
    end else begin
      strobe.oneshot_buzzer_fire <= shot_fire && (shot_state == pcr_pkg::PCR_SHOT_READY);
      strobe.envelope_restart    <= wr_f75 && wd[`PCR_BIT_D2];
      strobe.tick_timer_clear    <= wr_f76 && wd[`PCR_BIT_D1];
      strobe.dog_timer_clear     <= wr_f76 && wd[`PCR_BIT_D0];
      strobe.lap_timer_clear     <= wr_f77 && wd[`PCR_BIT_D1];
      strobe.prog_timer_clear    <= wr_f78 && wd[`PCR_BIT_D1];
      strobe.serial_clk_fire     <= wr_f7a && wd[`PCR_BIT_D3];   // see [R7]
    end
  end

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  // level outputs straight from the stored bits, no extra delay
  assign ctrl.envelope_enable     = envelope_enable;
  assign ctrl.envelope_period_sel = envelope_period_sel;
  assign ctrl.lap_timer_go        = lap_timer_go;
  assign ctrl.prog_timer_go       = prog_timer_go;
  assign ctrl.prog_timer_clk_out  = prog_timer_clock_cfg[`PCR_BIT_D3];  // see [R5]
  assign ctrl.prog_timer_src_sel  = prog_timer_clock_cfg[2:0];          // see [R6]
  assign ctrl.serial_clk_edge_sel = serial_clock_cfg[2];                // see [R8]
  assign ctrl.serial_clk_src_sel  = serial_clock_cfg[1:0];              // see [R9]
  assign ctrl.out_port_float      = output_float_ctrl;
  assign ctrl.io_port_dir         = io_direction_ctrl;
  assign ctrl.io_port_pullup_sel  = io_pullup_ctrl;

  // ----------------------------------------
  // read path, strobe bits read zero
  // ----------------------------------------
  // readback words, write-only and empty bits forced to zero
  wire logic [3:0]  rb_f75 = {buzzer_shot_active, 1'b0, envelope_period_sel, envelope_enable}; // see [R1] see [R2]
  wire logic [3:0]  rb_f76 = 4'h0;                                 // see [R2] see [R3]
  wire logic [3:0]  rb_f77 = {3'h0, lap_timer_go};                 // see [R2] see [R3]
  wire logic [3:0]  rb_f78 = {3'h0, prog_timer_go};                // see [R2] see [R3]
  wire logic [3:0]  rb_f7a = {1'b0, serial_clock_cfg};             // see [R2] see [R7]
  wire logic [11:0] ra     = bus.addr;

  // ----------------------------------------
  // address selection
  // ----------------------------------------
  // anything unmapped reads zero
  wire logic [3:0] read_mux =
    (ra == `PCR_BUZZER_ENVELOPE_CTRL) ? rb_f75 :
    (ra == `PCR_TIMER_CLEAR_STROBES)  ? rb_f76 :
    (ra == `PCR_STOPWATCH_CTRL)       ? rb_f77 :
    (ra == `PCR_PROG_TIMER_CTRL)      ? rb_f78 :
    (ra == `PCR_PROG_TIMER_CLOCK_CFG) ? prog_timer_clock_cfg :  // see [R5] see [R6]
    (ra == `PCR_SERIAL_CLOCK_CFG)     ? rb_f7a :
    (ra == `PCR_OUTPUT_FLOAT_CTRL)    ? output_float_ctrl :     // see [R10]
    (ra == `PCR_IO_DIRECTION_CTRL)    ? io_direction_ctrl :     // see [R12]
    (ra == `PCR_IO_PULLUP_CTRL)       ? io_pullup_ctrl : 4'h0;  // see [R11]

  // registered read data
  // rdata holds between reads, so a late sample still sees the last word
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= 4'h0;
    end else if (bus.rd) begin
      rdata <= read_mux;
    end
  end

endmodule : pcr_regs

`default_nettype wire

// File: sim/pcr_regs_monitor.sv
// checker for the peripheral control register bank
// assumes it is bound to pcr_regs and sees only its ports
`timescale 1ns/10ps
`include "pcr_defs.svh"
`default_nettype none

module pcr_regs_monitor (
  input wire logic                    clock,
  input wire logic                    resetn,
  input wire pcr_pkg::pcr_bus_type    bus,
  input wire logic                    shot_width_long,
  input wire logic [3:0]              rdata,
  input wire pcr_pkg::pcr_ctrl_type   ctrl,
  input wire pcr_pkg::pcr_strobe_type strobe,
  input wire logic                    buzzer_shot_active
);
  // ----------------------------------------
  // access decode
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic wr75 = bus.wr && bus.addr == `PCR_BUZZER_ENVELOPE_CTRL;
  wire logic wr79 = bus.wr && bus.addr == `PCR_PROG_TIMER_CLOCK_CFG;
  wire logic wr7a = bus.wr && bus.addr == `PCR_SERIAL_CLOCK_CFG;
  wire logic wr7b = bus.wr && bus.addr == `PCR_OUTPUT_FLOAT_CTRL;
  wire logic wr7d = bus.wr && bus.addr == `PCR_IO_DIRECTION_CTRL;
  wire logic wr7e = bus.wr && bus.addr == `PCR_IO_PULLUP_CTRL;
  wire logic rd75 = bus.rd && bus.addr == `PCR_BUZZER_ENVELOPE_CTRL;
  wire logic rdz  = bus.rd && (bus.addr == `PCR_TIMER_CLEAR_STROBES || bus.addr == `PCR_OUTPUT_FLOAT_CTRL + 12'h1);
  wire logic rdgo = bus.rd && (bus.addr == `PCR_STOPWATCH_CTRL || bus.addr == `PCR_PROG_TIMER_CTRL);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_shot; wr75 && bus.wdata[3] && !buzzer_shot_active |=> strobe.oneshot_buzzer_fire && buzzer_shot_active; endproperty
  a_shot: assert property (p_shot) else $error("shot not fired");
  property p_nofire; strobe.oneshot_buzzer_fire |-> $past(wr75 && bus.wdata[3] && !buzzer_shot_active); endproperty
  a_nofire: assert property (p_nofire) else $error("stray shot");
  property p_busyrd; rd75 |=> rdata == {$past(buzzer_shot_active), 1'b0,
    $past(ctrl.envelope_period_sel), $past(ctrl.envelope_enable)}; endproperty
  a_busyrd: assert property (p_busyrd) else $error("bad status read");
  property p_zerord; rdz |=> rdata == 4'h0; endproperty
  a_zerord: assert property (p_zerord) else $error("empty bits not zero");
  property p_gord; rdgo |=> rdata[3:1] == 3'h0; endproperty
  a_gord: assert property (p_gord) else $error("run register upper bits not zero");
  property p_ptclk; wr79 |=> {ctrl.prog_timer_clk_out, ctrl.prog_timer_src_sel} == $past(bus.wdata); endproperty
  a_ptclk: assert property (p_ptclk) else $error("timer clock cfg");
  property p_ser; wr7a |=> {strobe.serial_clk_fire, ctrl.serial_clk_edge_sel, ctrl.serial_clk_src_sel}
    == $past(bus.wdata); endproperty
  a_ser: assert property (p_ser) else $error("serial clock cfg");
  property p_float; wr7b |=> ctrl.out_port_float == $past(bus.wdata); endproperty
  a_float: assert property (p_float) else $error("float ctrl");
  property p_dir; wr7d |=> ctrl.io_port_dir == $past(bus.wdata); endproperty
  a_dir: assert property (p_dir) else $error("direction ctrl");
  property p_pup; wr7e |=> ctrl.io_port_pullup_sel == $past(bus.wdata); endproperty
  a_pup: assert property (p_pup) else $error("pullup ctrl");

  // main scenarios reached
  c_shot: cover property (wr75 && bus.wdata[3]);
  c_ser: cover property (strobe.serial_clk_fire);
  c_busy: cover property (rd75 && buzzer_shot_active);
endmodule : pcr_regs_monitor

bind pcr_regs pcr_regs_monitor i_pcr_regs_monitor (.clock(clock), .resetn(resetn), .bus(bus),
  .shot_width_long(shot_width_long), .rdata(rdata), .ctrl(ctrl), .strobe(strobe),
  .buzzer_shot_active(buzzer_shot_active));

`default_nettype wire

// File: sim/pcr_regs_tb.sv
// testbench for the peripheral control register bank
// assumes pcr_pkg, pcr_regs and the monitor are compiled first
`timescale 1ns/10ps
`include "pcr_defs.svh"
`default_nettype none

module pcr_regs_tb;
  logic                    clock;
  logic                    resetn;
  pcr_pkg::pcr_bus_type    bus;
  logic                    swl;
  logic [3:0]              rdata;
  pcr_pkg::pcr_ctrl_type   ctrl;
  pcr_pkg::pcr_strobe_type strobe;
  logic                    busy;
  int                      n_fail;
  int                      compares;

  pcr_regs i_pcr_regs (.clock(clock), .resetn(resetn), .bus(bus), .shot_width_long(swl),
    .rdata(rdata), .ctrl(ctrl), .strobe(strobe), .buzzer_shot_active(busy));

  // ----------------------------------------
  // clock and tasks
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [3:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
    #1;
  endtask : wr
  task rd(input logic [11:0] a, input logic [3:0] exp);
    @(posedge clock);
    bus <= '{a, 4'h0, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    chk(24'(rdata), 24'(exp));
  endtask : rd
  task stop_test;
    $display("n_fail %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    bus = '0;
    swl = 1'b0;
    n_fail = 0;
    compares = 0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    #1;
    chk(24'(ctrl), 24'h0);
    for (int i = 0; i < 10; i++) rd(`PCR_BUZZER_ENVELOPE_CTRL + 12'(i), 4'h0);
    wr(`PCR_PROG_TIMER_CLOCK_CFG, 4'h9);
    chk(24'({ctrl.prog_timer_clk_out, ctrl.prog_timer_src_sel}), 24'h9);
    wr(`PCR_PROG_TIMER_CLOCK_CFG, 4'h6);
    chk(24'(ctrl.prog_timer_clk_out), 24'h0);
    rd(`PCR_PROG_TIMER_CLOCK_CFG, 4'h6);
    wr(`PCR_SERIAL_CLOCK_CFG, 4'hF);
    chk(24'(strobe), 24'h02);
    rd(`PCR_SERIAL_CLOCK_CFG, 4'h7);
    wr(`PCR_SERIAL_CLOCK_CFG, 4'h5);
    chk(24'({ctrl.serial_clk_edge_sel, ctrl.serial_clk_src_sel}), 24'h5);
    wr(`PCR_OUTPUT_FLOAT_CTRL, 4'hA);
    wr(`PCR_IO_DIRECTION_CTRL, 4'h5);
    wr(`PCR_IO_PULLUP_CTRL, 4'hC);
    chk(24'({ctrl.out_port_float, ctrl.io_port_dir, ctrl.io_port_pullup_sel}), 24'hA5C);
    rd(`PCR_OUTPUT_FLOAT_CTRL, 4'hA);
    rd(`PCR_IO_DIRECTION_CTRL, 4'h5);
    rd(`PCR_IO_PULLUP_CTRL, 4'hC);
    wr(`PCR_TIMER_CLEAR_STROBES, 4'hF);
    chk(24'(strobe), 24'h30);
    rd(`PCR_TIMER_CLEAR_STROBES, 4'h0);
    wr(`PCR_STOPWATCH_CTRL, 4'hF);
    chk(24'(strobe), 24'h08);
    rd(`PCR_STOPWATCH_CTRL, 4'h1);
    wr(`PCR_PROG_TIMER_CTRL, 4'hF);
    chk(24'(strobe), 24'h04);
    rd(`PCR_PROG_TIMER_CTRL, 4'h1);
    chk(24'({ctrl.lap_timer_go, ctrl.prog_timer_go}), 24'h3);
    wr(`PCR_STOPWATCH_CTRL, 4'h0);
    chk(24'({ctrl.lap_timer_go, ctrl.prog_timer_go}), 24'h1);
    wr(`PCR_BUZZER_ENVELOPE_CTRL, 4'h3);
    chk(24'({ctrl.envelope_period_sel, ctrl.envelope_enable}), 24'h3);
    rd(`PCR_BUZZER_ENVELOPE_CTRL, 4'h3);
    wr(`PCR_BUZZER_ENVELOPE_CTRL, 4'hF);
    chk(24'(strobe), 24'h41);
    chk(24'(busy), 24'h1);
    rd(`PCR_BUZZER_ENVELOPE_CTRL, 4'hB);
    wr(`PCR_BUZZER_ENVELOPE_CTRL, 4'h8);
    chk(24'(strobe), 24'h00);
    chk(24'({ctrl.envelope_period_sel, ctrl.envelope_enable}), 24'h0);
    rd(`PCR_BUZZER_ENVELOPE_CTRL, 4'h8);
    // reset again in mid-run
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(24'({ctrl, busy}), 24'h0);
    chk(24'(strobe), 24'h0);
    @(posedge clock);
    resetn <= 1'b1;
    rd(`PCR_OUTPUT_FLOAT_CTRL, 4'h0);
    rd(`PCR_BUZZER_ENVELOPE_CTRL, 4'h0);
    stop_test();
  end
endmodule : pcr_regs_tb

`default_nettype wire
